// ### src/cip_consts.svh
// Purpose: Register offsets, reset values and field positions of the channel interrupt block.
// Assumes: Byte-wide registers on a 7-bit plain register port.
// Notes: Channel B window is channel A plus the channel stride.
`ifndef CIP_CONSTS_SVH
`define CIP_CONSTS_SVH
`define CIP_OFS_RX_IRQ 7'h3A
`define CIP_OFS_TX_IRQ 7'h3B
`define CIP_OFS_PORT_VALUE 7'h3C
`define CIP_OFS_PORT_IRQ 7'h3D
`define CIP_OFS_PORT_DIR 7'h3E
`define CIP_OFS_CONFIG 7'h30
`define CIP_OFS_GLOBAL 7'h31
`define CIP_OFS_CTS_LEVEL 7'h32
`define CIP_CH_STRIDE 7'h40
`define CIP_MASK_RESET 8'hFF
`define CIP_DIR_RESET 8'hFF
`define CIP_CONFIG_RESET 8'h00
`define CIP_CFG_VISIBLE 0
`define CIP_CFG_IRQ_MODE 1
`define CIP_CFG_BUS_MODE 2
`define CIP_TX_POOL_READY 0
`define CIP_TX_REPEAT 1
`define CIP_TX_CTS_CHANGE 2
`define CIP_TX_TIMER 3
`define CIP_TX_UNDERRUN 4
`define CIP_TX_ALL_SENT 5
`define CIP_RX_POOL_FULL 0
`define CIP_RX_OVERFLOW 1
`define CIP_GIS_RX 0
`define CIP_GIS_TX 1
`define CIP_GIS_PORT 2
`endif

// ### src/cip_pkg.sv
// Purpose: Types shared by the channel interrupt block.
// Assumes: Two channels, eight port pins.
// Notes: Event groups travel as packed structs.
package cip_pkg;
	typedef struct packed {
		logic rx_full_hit;
		logic rx_char_in;
		logic rx_at_threshold;
	} cip_rx_ev_t;
	typedef struct packed {
		logic tx_fifo_empty;
		logic tx_shift_done;
		logic tx_block_active;
		logic tx_fifo_has_data;
		logic tx_can_take_block;
		logic collision;
		logic char_in_flight;
		logic timer_expired;
		logic cts_level;
	} cip_tx_ev_t;
	typedef enum logic [1:0] {
		CIP_TX_RUN = 2'b01,
		CIP_TX_HOLD = 2'b10
	} cip_tx_st_t;
endpackage

// ### src/cip_top.sv
// Purpose: Per-channel interrupt status, masks, and shared 8-bit general purpose port.
// Assumes: All events are from logic on i_clk except port pins and CTS, which are synchronised.
// Notes: Read data stand one cycle after the read strobe; status clears on that read.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
`include "cip_consts.svh"
module cip_top (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Register port.
	input wire logic [6:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// Channel events, index is the channel.
	input wire cip_pkg::cip_rx_ev_t [1:0] i_rx_ev,
	input wire cip_pkg::cip_tx_ev_t [1:0] i_tx_ev,
	input wire logic [1:0] i_vector_ack,
	// Channel transmitter control.
	output logic [1:0] o_tx_idle_fill,
	output logic [1:0] o_tx_hold,
	// Interrupt.
	output logic o_irq,
	// Port pins.
	input wire logic [7:0] i_port_pin,
	output logic [7:0] o_port_pin,
	output logic [7:0] o_port_oe
);
	logic [1:0][7:0] rx_stat_q, tx_stat_q, rx_mask_q, tx_mask_q;
	logic [1:0][7:0] cfg_q;
	logic [1:0][7:0] rx_set, tx_set;
	logic [1:0] rd_rx, rd_tx, wr_rx, wr_tx, rd_cts, rd_cfg, rd_gis, wr_cfg;
	logic [1:0][2:0] cts_sync_q;
	logic [1:0] cts_lvl_q;
	cip_pkg::cip_tx_st_t [1:0] tx_st_q;
	logic [1:0] idle_fill_q;
	logic [7:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;
	logic [7:0] pout_q, pdir_q, pmask_q, ppend_q;
	logic [7:0] pin_edge, p_vis, p_act;
	logic [1:0][2:0] global_irq_status;
	logic [6:0] loc;
	logic rd_pval, wr_pval, rd_pis, wr_pim, rd_pdir, wr_pdir;
	logic [7:0] rdata_d;

	assign loc = i_addr & ~`CIP_CH_STRIDE;
	assign rd_pval = i_rd && loc == `CIP_OFS_PORT_VALUE;
	assign wr_pval = i_wr && loc == `CIP_OFS_PORT_VALUE;
	assign rd_pis = i_rd && loc == `CIP_OFS_PORT_IRQ;
	assign wr_pim = i_wr && loc == `CIP_OFS_PORT_IRQ;
	assign rd_pdir = i_rd && loc == `CIP_OFS_PORT_DIR;
	assign wr_pdir = i_wr && loc == `CIP_OFS_PORT_DIR;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pin_s1_q <= 8'h00;
			pin_s2_q <= 8'h00;
			pin_s3_q <= 8'h00;
			pin_lvl_q <= 8'h00;
		end else begin
			pin_s1_q <= i_port_pin;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_lvl_q <= (pin_s2_q & pin_s3_q) | (pin_lvl_q & (pin_s2_q | pin_s3_q));
		end
	end

	assign pin_edge = (pin_lvl_q ^ ((pin_s2_q & pin_s3_q) | (pin_lvl_q & (pin_s2_q | pin_s3_q))))
		& pdir_q;
	assign p_vis = ppend_q & (~pmask_q | {8{cfg_q[0][`CIP_CFG_VISIBLE]}});
	assign p_act = ppend_q & ~pmask_q;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pmask_q <= `CIP_MASK_RESET;
			pdir_q <= `CIP_DIR_RESET;
			pout_q <= 8'h00;
		end else begin
			if (wr_pim) begin
				pmask_q <= i_wdata;
			end
			if (wr_pdir) begin
				pdir_q <= i_wdata;
			end
			if (wr_pval) begin
				pout_q <= (i_wdata & ~pdir_q) | (pout_q & pdir_q);
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ppend_q <= 8'h00;
		end else begin
			ppend_q <= (ppend_q & ~(rd_pis ? p_vis : 8'h00)) | pin_edge;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_port_pin <= 8'h00;
			o_port_oe <= 8'h00;
		end else begin
			o_port_pin <= pout_q;
			o_port_oe <= ~pdir_q;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			logic cts_new, cts_drop, underrun;
			logic ch_sel;
			assign ch_sel = i_addr[6] == ch[0];
			assign rd_rx[ch] = i_rd && ch_sel && loc == `CIP_OFS_RX_IRQ;
			assign wr_rx[ch] = i_wr && ch_sel && loc == `CIP_OFS_RX_IRQ;
			assign rd_tx[ch] = i_rd && ch_sel && loc == `CIP_OFS_TX_IRQ;
			assign wr_tx[ch] = i_wr && ch_sel && loc == `CIP_OFS_TX_IRQ;
			assign rd_cfg[ch] = i_rd && ch_sel && loc == `CIP_OFS_CONFIG;
			assign wr_cfg[ch] = i_wr && ch_sel && loc == `CIP_OFS_CONFIG;
			assign rd_gis[ch] = i_rd && ch_sel && loc == `CIP_OFS_GLOBAL;
			assign rd_cts[ch] = i_rd && ch_sel && loc == `CIP_OFS_CTS_LEVEL;
			assign cts_new = (cts_sync_q[ch][1] & cts_sync_q[ch][2])
				| (cts_lvl_q[ch] & (cts_sync_q[ch][1] | cts_sync_q[ch][2]));
			assign cts_drop = cts_lvl_q[ch] & ~cts_new;
			assign underrun = tx_st_q[ch] == cip_pkg::CIP_TX_RUN
				&& i_tx_ev[ch].tx_block_active && !i_tx_ev[ch].tx_fifo_has_data;

			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					cts_sync_q[ch] <= 3'h0;
					cts_lvl_q[ch] <= 1'b0;
				end else begin
					cts_sync_q[ch] <= {cts_sync_q[ch][1:0], i_tx_ev[ch].cts_level};
					cts_lvl_q[ch] <= cts_new;
				end
			end

			always_comb begin
				rx_set[ch] = 8'h00;
				tx_set[ch] = 8'h00;
				rx_set[ch][`CIP_RX_OVERFLOW] = i_rx_ev[ch].rx_full_hit & i_rx_ev[ch].rx_char_in;
				rx_set[ch][`CIP_RX_POOL_FULL] = i_rx_ev[ch].rx_at_threshold
					& cfg_q[ch][`CIP_CFG_IRQ_MODE];
				tx_set[ch][`CIP_TX_POOL_READY] = i_tx_ev[ch].tx_can_take_block
					& tx_st_q[ch] == cip_pkg::CIP_TX_RUN;
				tx_set[ch][`CIP_TX_REPEAT] = cfg_q[ch][`CIP_CFG_BUS_MODE]
					? i_tx_ev[ch].collision : (cts_drop & i_tx_ev[ch].char_in_flight);
				tx_set[ch][`CIP_TX_CTS_CHANGE] = cts_new ^ cts_lvl_q[ch];
				tx_set[ch][`CIP_TX_TIMER] = i_tx_ev[ch].timer_expired;
				tx_set[ch][`CIP_TX_UNDERRUN] = underrun;
				tx_set[ch][`CIP_TX_ALL_SENT] = i_tx_ev[ch].tx_fifo_empty
					& i_tx_ev[ch].tx_shift_done;
			end

			// visibility gating; set wins over clear.
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					rx_stat_q[ch] <= 8'h00;
					tx_stat_q[ch] <= 8'h00;
				end else begin
					rx_stat_q[ch] <= (rd_rx[ch] ? 8'h00 : rx_stat_q[ch]) | (rx_set[ch]
						& (~rx_mask_q[ch] | {8{cfg_q[ch][`CIP_CFG_VISIBLE]}}));
					tx_stat_q[ch] <= ((rd_tx[ch] ? 8'h00 : tx_stat_q[ch])
						& ~(i_vector_ack[ch] ? 8'h01 : 8'h00))
						| (tx_set[ch] & (~tx_mask_q[ch] | {8{cfg_q[ch][`CIP_CFG_VISIBLE]}}));
				end
			end

			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					rx_mask_q[ch] <= `CIP_MASK_RESET;
					tx_mask_q[ch] <= `CIP_MASK_RESET;
					cfg_q[ch] <= `CIP_CONFIG_RESET;
				end else begin
					if (wr_rx[ch]) begin
						rx_mask_q[ch] <= i_wdata;
					end
					if (wr_tx[ch]) begin
						tx_mask_q[ch] <= i_wdata;
					end
					if (wr_cfg[ch]) begin
						cfg_q[ch] <= i_wdata;
					end
				end
			end

			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					tx_st_q[ch] <= cip_pkg::CIP_TX_RUN;
					idle_fill_q[ch] <= 1'b0;
				end else begin
					idle_fill_q[ch] <= underrun;
					unique case (tx_st_q[ch])
						cip_pkg::CIP_TX_RUN: begin
							if (underrun) begin
								tx_st_q[ch] <= cip_pkg::CIP_TX_HOLD;
							end
						end
						cip_pkg::CIP_TX_HOLD: begin
							if (rd_tx[ch]) begin
								tx_st_q[ch] <= cip_pkg::CIP_TX_RUN;
							end
						end
						default: begin
							tx_st_q[ch] <= cip_pkg::CIP_TX_RUN;
						end
					endcase
				end
			end

			assign global_irq_status[ch][`CIP_GIS_RX] = |(rx_stat_q[ch] & ~rx_mask_q[ch]);
			assign global_irq_status[ch][`CIP_GIS_TX] = |(tx_stat_q[ch] & ~tx_mask_q[ch]);
			assign global_irq_status[ch][`CIP_GIS_PORT] = |p_act;
		end
	endgenerate

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_tx_idle_fill <= 2'b00;
			o_tx_hold <= 2'b00;
			o_irq <= 1'b0;
		end else begin
			o_tx_idle_fill <= idle_fill_q;
			o_tx_hold <= {tx_st_q[1] == cip_pkg::CIP_TX_HOLD, tx_st_q[0] == cip_pkg::CIP_TX_HOLD};
			o_irq <= |global_irq_status[0] | |global_irq_status[1][1:0];
		end
	end

	// Read mux; unmapped addresses read zero.
	always_comb begin
		rdata_d = 8'h00;
		for (int c = 0; c < 2; c++) begin
			if (rd_rx[c]) begin
				rdata_d = rx_stat_q[c];
			end
			if (rd_tx[c]) begin
				rdata_d = tx_stat_q[c];
			end
			if (rd_cfg[c]) begin
				rdata_d = cfg_q[c];
			end
			if (rd_gis[c]) begin
				rdata_d = {5'h00, global_irq_status[c]};
			end
			if (rd_cts[c]) begin
				rdata_d = {7'h00, cts_lvl_q[c]};
			end
		end
		if (rd_pval) begin
			rdata_d = pin_lvl_q;
		end
		if (rd_pis) begin
			rdata_d = p_vis;
		end
		if (rd_pdir) begin
			rdata_d = pdir_q;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= rdata_d;
		end
	end
endmodule

// ### sim/cip_top_sva.sv
// Purpose: Concurrent checks on the channel interrupt block ports.
// Assumes: Channel A transmitter and the shared port.
// Notes: Bound to every cip_top instance.
`timescale 1ns/1ns
module cip_top_chk (
	// Clock, reset and register port.
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [6:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	// Transmitter and port.
	input wire cip_pkg::cip_tx_ev_t [1:0] i_tx_ev,
	input wire logic [1:0] o_tx_idle_fill,
	input wire logic [1:0] o_tx_hold,
	input wire logic [7:0] o_port_pin,
	input wire logic [7:0] o_port_oe
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	logic dry;
	logic rd_tx;
	assign dry = i_tx_ev[0].tx_block_active && !i_tx_ev[0].tx_fifo_has_data;
	assign rd_tx = i_rd && i_addr == 7'h3B;
	chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside read cycle");
	chk_unmapped_zero: assert property (i_rd && i_addr == 7'h55 |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_dir_write: assert property (i_wr && i_addr[5:0] == 6'h3E
		|-> ##2 o_port_oe == ~$past(i_wdata, 2))
		else $error("direction write not applied");
	chk_dir_stable: assert property (!(i_wr && i_addr[5:0] == 6'h3E) |-> ##2 $stable(o_port_oe))
		else $error("pin direction moved");
	chk_pin_write: assert property (i_wr && i_addr[5:0] == 6'h3C
		|-> ##2 ((o_port_pin ^ $past(i_wdata, 2)) & o_port_oe) == 8'h00)
		else $error("output pin value wrong");
	chk_hold_entry: assert property (dry && !o_tx_hold[0] |-> ##[1:3] o_tx_hold[0])
		else $error("underrun did not hold transmitter");
	chk_idle_fill: assert property ($rose(dry) && !o_tx_hold[0] |-> ##[1:3] o_tx_idle_fill[0])
		else $error("underrun without idle fill");
	chk_hold_release: assert property ($fell(o_tx_hold[0]) |-> $past(rd_tx) || $past(rd_tx, 2))
		else $error("hold released without status read");
	cover property ($rose(o_tx_hold[0]));
	cover property ($rose(o_tx_idle_fill[0]));
	cover property (i_wr && i_addr[5:0] == 6'h3E);
endmodule
bind cip_top cip_top_chk u_cip_top_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tx_ev(i_tx_ev),
	.o_tx_idle_fill(o_tx_idle_fill), .o_tx_hold(o_tx_hold), .o_port_pin(o_port_pin),
	.o_port_oe(o_port_oe));

// ### sim/cip_pin_model.sv
// Purpose: Board model of the eight port pins.
// Assumes: Outside drivers act only where the block does not drive.
// Notes: Pin level merges block drive and outside drive.
`timescale 1ns/1ns
module cip_pin_model (
	// Block side.
	input wire logic [7:0] i_drive,
	input wire logic [7:0] i_oe,
	// Board side.
	input wire logic [7:0] i_ext,
	output logic [7:0] o_level
);
	assign o_level = (i_drive & i_oe) | (i_ext & ~i_oe);
endmodule

// ### sim/cip_top_tb_top.sv
// Purpose: Bench for the channel interrupt block.
// Assumes: Channel A events and the shared port.
// Notes: Expected values follow the register map.
`timescale 1ns/1ns
module cip_top_tb_top;
	logic i_clk, i_rst_n, i_wr, i_rd, o_irq;
	logic [6:0] i_addr;
	logic [7:0] i_wdata, ext, lvl, o_rdata, o_port_pin, o_port_oe;
	logic [1:0] i_vector_ack, o_tx_idle_fill, o_tx_hold;
	cip_pkg::cip_rx_ev_t [1:0] i_rx_ev;
	cip_pkg::cip_tx_ev_t [1:0] i_tx_ev;
	int bad_count = 0;
	int compares = 0;
	cip_top u_cip_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_ev(i_rx_ev), .i_tx_ev(i_tx_ev),
		.i_vector_ack(i_vector_ack), .o_tx_idle_fill(o_tx_idle_fill), .o_tx_hold(o_tx_hold),
		.o_irq(o_irq), .i_port_pin(lvl), .o_port_pin(o_port_pin), .o_port_oe(o_port_oe));
	cip_pin_model u_cip_pin_model (.i_drive(o_port_pin), .i_oe(o_port_oe), .i_ext(ext),
		.o_level(lvl));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmp1(input string what, input logic exp, input logic got);
		cmp(what, {7'h00, exp}, {7'h00, got});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string what);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		cmp(what, exp, o_rdata);
	endtask
	task automatic pulse(input cip_pkg::cip_rx_ev_t rx, input cip_pkg::cip_tx_ev_t tx);
		@(posedge i_clk);
		i_rx_ev[0] <= rx;
		i_tx_ev[0] <= tx;
		@(posedge i_clk);
		i_rx_ev[0] <= '0;
		i_tx_ev[0] <= '0;
	endtask
	task automatic wrap_up();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		i_rst_n = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 7'h00;
		i_wdata = 8'h00;
		i_rx_ev = '0;
		i_tx_ev = '0;
		i_vector_ack = 2'h0;
		ext = 8'h00;
		tick(6);
		i_rst_n <= 1'b1;
		rd(7'h3E, 8'hFF, "dir");
		cmp("oe", 8'h00, o_port_oe);
		rd(7'h55, 8'h00, "unmapped");
		wr(7'h7E, 8'hF0);
		wr(7'h7C, 8'hA5);
		ext <= 8'h30;
		tick(5);
		cmp("oe", 8'h0F, o_port_oe);
		rd(7'h3C, 8'h35, "pins");
		rd(7'h3D, 8'h00, "port hidden");
		cmp1("irq masked", 1'b0, o_irq);
		wr(7'h3D, 8'hEF);
		tick(3);
		cmp1("irq pending", 1'b1, o_irq);
		rd(7'h7D, 8'h10, "port pin4");
		ext <= 8'h20;
		tick(4);
		ext <= 8'h30;
		tick(5);
		rd(7'h3D, 8'h10, "port twice");
		rd(7'h3D, 8'h00, "port once");
		wr(7'h3D, 8'hCE);
		tick(3);
		rd(7'h3D, 8'h20, "port pin5");
		wr(7'h3C, 8'hA4);
		tick(5);
		rd(7'h3D, 8'h00, "port output");
		cmp1("irq idle", 1'b0, o_irq);
		wr(7'h30, 8'h01);
		pulse(3'h0, 9'h002);
		tick(3);
		cmp1("irq visible", 1'b0, o_irq);
		rd(7'h3B, 8'h08, "timer");
		rd(7'h3B, 8'h00, "tx cleared");
		wr(7'h3B, 8'hE7);
		pulse(3'h0, 9'h002);
		tick(3);
		cmp1("irq timer", 1'b1, o_irq);
		rd(7'h3B, 8'h08, "timer");
		tick(2);
		cmp1("irq cleared", 1'b0, o_irq);
		pulse(3'h0, 9'h040);
		tick(4);
		cmp1("hold", 1'b1, o_tx_hold[0]);
		rd(7'h3B, 8'h10, "underrun");
		tick(2);
		cmp1("release", 1'b0, o_tx_hold[0]);
		pulse(3'h0, 9'h180);
		rd(7'h3B, 8'h20, "all sent");
		pulse(3'h0, 9'h010);
		rd(7'h3B, 8'h01, "pool ready");
		pulse(3'h0, 9'h010);
		@(posedge i_clk);
		i_vector_ack <= 2'b01;
		@(posedge i_clk);
		i_vector_ack <= 2'b00;
		rd(7'h3B, 8'h00, "vector clear");
		@(posedge i_clk);
		i_tx_ev[0] <= 9'h001;
		tick(6);
		rd(7'h3B, 8'h04, "cts rise");
		rd(7'h32, 8'h01, "cts level");
		@(posedge i_clk);
		i_tx_ev[0] <= 9'h004;
		tick(6);
		rd(7'h3B, 8'h06, "cts loss");
		@(posedge i_clk);
		i_tx_ev[0] <= '0;
		wr(7'h30, 8'h05);
		pulse(3'h0, 9'h008);
		rd(7'h3B, 8'h02, "collision");
		pulse(3'h1, 9'h000);
		tick(3);
		rd(7'h3A, 8'h00, "no irq mode");
		wr(7'h30, 8'h03);
		wr(7'h3A, 8'hFD);
		pulse(3'h7, 9'h000);
		tick(3);
		cmp1("irq rx", 1'b1, o_irq);
		rd(7'h3A, 8'h03, "rx");
		wrap_up();
	end
	initial begin
		#20000;
		bad_count++;
		wrap_up();
	end
endmodule
